// ### src/lcb_csr_bank.sv
// control and status register bank of the link controller, two access windows
`timescale 1ns/1ps
`include "lcb_csr_map.svh"

// Operation
// - writing ones to the clear port clears those node condition bits.
// - writing ones to the set port sets those node condition bits.
// - one register holds current node id and the id captured at reset.
// - any write to the command reset trigger starts a chip command reset at once.
// - detected errors are counted and the count is readable.
// - a programmable sync packet spacing register is held and driven out.
// - line-side routing table: sixteen 16-bit entries at consecutive words.
// - back-end link routing table: sixteen 16-bit entries at consecutive words.
// - routing control and node identifier mask registers steer routing.
// - 80-bit unique id held as bits 15:0, 31:16 and 79:64.
// - perf counter counts selected events; software writes only clear it.
// - software condition clear port clears each bit written as one.
// - software condition set port sets each bit written as one.
// - the mirror address returns the maker identification value.
// - bank reachable from the direct csr window and the mapped window.
module lcb_csr_bank
  import lcb_pkg::*;
#(
  parameter logic [31:0] MAKER_IDENT_VALUE = 32'h0000_5A5A  // arbitrary value
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RESET_N,
  input  wire logic                  DWIN_REQ,
  input  wire logic                  DWIN_WE,
  input  wire logic [`LCB_ADDR_W-1:0] DWIN_ADDR,
  input  wire logic [31:0]           DWIN_WDATA,
  output logic                       DWIN_ACK,
  input  wire logic                  MWIN_REQ,
  input  wire logic                  MWIN_WE,
  input  wire logic [`LCB_ADDR_W-1:0] MWIN_ADDR,
  input  wire logic [31:0]           MWIN_WDATA,
  output logic                       MWIN_ACK,
  output logic [31:0]                RDATA,
  input  wire logic [15:0]           STRAP_NODE_ID,
  input  wire logic [31:0]           NODE_COND_EVENTS,
  input  wire logic                  FAULT_EVENT,
  input  wire logic [31:0]           PERF_EVENTS,
  output logic                       CMD_RESET_PULSE,
  output logic [31:0]                NODE_CONDITION,
  output logic [15:0]                NODE_ID,
  output logic [31:0]                SYNC_SPACING,
  output logic [31:0]                ROUTE_CTRL,
  output logic [31:0]                ROUTE_MASK
);

  // ---------------------------------------------------------------
  // window selection
  // ---------------------------------------------------------------
  lcb_src_type             src;
  logic                    acc_we;
  logic [`LCB_ADDR_W-1:0]  acc_addr;
  logic [31:0]             acc_wdata;
  logic                    wr;
  logic                    rd;

  // direct window wins a tie; a port is not retaken while its ack stands
  always_comb begin
    src       = LCB_SRC_NONE;
    acc_we    = 1'b0;
    acc_addr  = '0;
    acc_wdata = '0;
    if (DWIN_REQ && !DWIN_ACK) begin
      src       = LCB_SRC_DIRECT;
      acc_we    = DWIN_WE;
      acc_addr  = DWIN_ADDR;
      acc_wdata = DWIN_WDATA;
    end else if (MWIN_REQ && !MWIN_ACK) begin
      src       = LCB_SRC_MAPPED;
      acc_we    = MWIN_WE;
      acc_addr  = MWIN_ADDR;
      acc_wdata = MWIN_WDATA;
    end
  end

  assign wr = (src != LCB_SRC_NONE) && acc_we;
  assign rd = (src != LCB_SRC_NONE) && !acc_we;

  function automatic logic hit(input logic [`LCB_ADDR_W-1:0] off);
    return wr && (acc_addr == off);
  endfunction : hit

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0]   node_cond_reg;
  logic [15:0]   node_id_reg;
  logic [15:0]   init_node_id_reg;
  logic          strap_taken_reg;
  logic          cmd_reset_reg;
  logic [31:0]   fault_tally_reg;
  logic [31:0]   sync_spacing_reg;
  lcb_table_type line_tbl_reg;
  lcb_table_type back_tbl_reg;
  logic [31:0]   rt_ctrl_reg;
  logic [31:0]   rt_mask_reg;
  logic [15:0]   uid_lo_reg;
  logic [15:0]   uid_mid_reg;
  logic [15:0]   uid_up_reg;
  logic [31:0]   gword_reg [8];
  logic [31:0]   perf_counter_command_reg;
  logic [31:0]   perf_counter_extension_reg;
  logic [31:0]   perf_counter_selector_reg;
  logic [31:0]   perf_event_tally_reg;
  logic [31:0]   sw_cond_reg;
  logic [31:0]   rdata_next;
  logic          line_hit;
  logic          back_hit;
  logic          perf_tick;

  assign line_hit = (acc_addr >= `LCB_OFF_LINE_TBL) && (acc_addr <= `LCB_OFF_LINE_END)
                    && (acc_addr[1:0] == 2'h0);
  assign back_hit = (acc_addr >= `LCB_OFF_BACK_TBL) && (acc_addr <= `LCB_OFF_BACK_END)
                    && (acc_addr[1:0] == 2'h0);

  // node condition: hardware sets beat a software clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      node_cond_reg <= `LCB_RESET_WORD;
    end else if (cmd_reset_reg) begin
      node_cond_reg <= NODE_COND_EVENTS;
    end else if (hit(`LCB_OFF_COND_CLR)) begin
      node_cond_reg <= (node_cond_reg & ~acc_wdata) | NODE_COND_EVENTS;
    end else if (hit(`LCB_OFF_COND_SET)) begin
      node_cond_reg <= node_cond_reg | acc_wdata | NODE_COND_EVENTS;
    end else begin
      node_cond_reg <= node_cond_reg | NODE_COND_EVENTS;
    end
  end

  // initial id is caught on the first clock after reset release, never by the reset itself
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_taken_reg  <= 1'b0;
      init_node_id_reg <= `LCB_RESET_HALF;
      node_id_reg      <= `LCB_RESET_HALF;
    end else if (!strap_taken_reg || cmd_reset_reg) begin
      strap_taken_reg  <= 1'b1;
      init_node_id_reg <= STRAP_NODE_ID;
      node_id_reg      <= STRAP_NODE_ID;
    end else if (hit(`LCB_OFF_NODE_IDENTIFIERS)) begin
      node_id_reg <= acc_wdata[15:0];
    end
  end

  // any write data starts the reset; one-cycle pulse to the rest of the chip
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmd_reset_reg <= 1'b0;
    end else begin
      cmd_reset_reg <= hit(`LCB_OFF_CMD_RST);
    end
  end

  // error count: a fault in the write cycle is added on top of the written value
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fault_tally_reg <= `LCB_RESET_WORD;
    end else if (hit(`LCB_OFF_FAULTS)) begin
      fault_tally_reg <= acc_wdata + {31'h0, FAULT_EVENT};
    end else if (FAULT_EVENT) begin
      fault_tally_reg <= fault_tally_reg + 32'h1;
    end
  end

  // plain read/write words: sync spacing, routing control and mask, unique id
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_spacing_reg <= `LCB_RESET_WORD;
      rt_ctrl_reg      <= `LCB_RESET_WORD;
      rt_mask_reg      <= `LCB_RESET_WORD;
      uid_lo_reg       <= `LCB_RESET_HALF;
      uid_mid_reg      <= `LCB_RESET_HALF;
      uid_up_reg       <= `LCB_RESET_HALF;
    end else begin
      if (hit(`LCB_OFF_SYNC))    sync_spacing_reg <= acc_wdata;
      if (hit(`LCB_OFF_RT_CTRL)) rt_ctrl_reg <= acc_wdata;
      if (hit(`LCB_OFF_RT_MASK)) rt_mask_reg <= acc_wdata;
      if (hit(`LCB_OFF_UID_LO))  uid_lo_reg  <= acc_wdata[15:0];
      if (hit(`LCB_OFF_UID_MID)) uid_mid_reg <= acc_wdata[15:0];
      if (hit(`LCB_OFF_UID_UP))  uid_up_reg  <= acc_wdata[15:0];
    end
  end

  // routing tables, one word each, upper half of the word is not stored
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < 16; i++) begin
        line_tbl_reg[i] <= `LCB_RESET_HALF;
        back_tbl_reg[i] <= `LCB_RESET_HALF;
      end
    end else if (wr && line_hit) begin
      line_tbl_reg[acc_addr[5:2]] <= acc_wdata[15:0];
    end else if (wr && back_hit) begin
      back_tbl_reg[acc_addr[5:2]] <= acc_wdata[15:0];
    end
  end

  // general words whose only effect is to hold what software wrote
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < 8; i++) gword_reg[i] <= `LCB_RESET_WORD;
    end else begin
      if (hit(`LCB_OFF_SETUP1)) gword_reg[LCB_GW_SETUP1] <= acc_wdata;
      if (hit(`LCB_OFF_SETUP2)) gword_reg[LCB_GW_SETUP2] <= acc_wdata;
      if (hit(`LCB_OFF_SETUP3)) gword_reg[LCB_GW_SETUP3] <= acc_wdata;
      if (hit(`LCB_OFF_FLOG))   gword_reg[LCB_GW_FLOG]   <= acc_wdata;
      if (hit(`LCB_OFF_DIAG))   gword_reg[LCB_GW_DIAG]   <= acc_wdata;
      if (hit(`LCB_OFF_HWINIT)) gword_reg[LCB_GW_HWINIT] <= acc_wdata;
      if (hit(`LCB_OFF_SOFTWARE_MAILBOX_WORD)) gword_reg[LCB_GW_SOFTWARE_MAILBOX_WORD] <= acc_wdata;
      if (hit(`LCB_OFF_LOCK))   gword_reg[LCB_GW_LOCK]   <= acc_wdata;
    end
  end

  // performance counter: selected event line, gated by the command enable bit
  assign perf_tick = perf_counter_command_reg[`LCB_PC_ENABLE_BIT]
                     && PERF_EVENTS[perf_counter_selector_reg[`LCB_PERF_COUNTER_SELECTOR_W-1:0]];

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      perf_counter_command_reg <= `LCB_RESET_WORD;
      perf_counter_extension_reg <= `LCB_RESET_WORD;
      perf_counter_selector_reg <= `LCB_RESET_WORD;
      perf_event_tally_reg <= `LCB_RESET_WORD;
    end else begin
      if (hit(`LCB_OFF_PERF_COUNTER_COMMAND)) perf_counter_command_reg <= acc_wdata;
      if (hit(`LCB_OFF_PERF_COUNTER_EXTENSION)) perf_counter_extension_reg <= acc_wdata;
      if (hit(`LCB_OFF_PERF_COUNTER_SELECTOR)) perf_counter_selector_reg <= acc_wdata;
      // write data is ignored: a write can only clear, and an event in that cycle still counts
      if (hit(`LCB_OFF_PERF_EVENT_TALLY)) begin
        perf_event_tally_reg <= {31'h0, perf_tick};
      end else if (perf_tick) begin
        perf_event_tally_reg <= perf_event_tally_reg + 32'h1;
      end
    end
  end

  // software condition word, bitwise clear and set ports
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sw_cond_reg <= `LCB_RESET_WORD;
    end else if (hit(`LCB_OFF_SW_CLR)) begin
      sw_cond_reg <= sw_cond_reg & ~acc_wdata;
    end else if (hit(`LCB_OFF_SW_SET)) begin
      sw_cond_reg <= sw_cond_reg | acc_wdata;
    end
  end

  // ---------------------------------------------------------------
  // read return
  // ---------------------------------------------------------------
  // write-only and unlisted offsets read as zero
  always_comb begin
    rdata_next = '0;
    if (line_hit) begin
      rdata_next = {16'h0, line_tbl_reg[acc_addr[5:2]]};
    end else if (back_hit) begin
      rdata_next = {16'h0, back_tbl_reg[acc_addr[5:2]]};
    end else begin
      case (acc_addr)
        `LCB_OFF_COND_CLR,
        `LCB_OFF_COND_SET: rdata_next = node_cond_reg;
        `LCB_OFF_NODE_IDENTIFIERS: rdata_next = {init_node_id_reg, node_id_reg};
        `LCB_OFF_FAULTS:   rdata_next = fault_tally_reg;
        `LCB_OFF_SYNC:     rdata_next = sync_spacing_reg;
        `LCB_OFF_UID_UP:   rdata_next = {16'h0, uid_up_reg};
        `LCB_OFF_RT_CTRL:  rdata_next = rt_ctrl_reg;
        `LCB_OFF_RT_MASK:  rdata_next = rt_mask_reg;
        `LCB_OFF_SETUP1:   rdata_next = gword_reg[LCB_GW_SETUP1];
        `LCB_OFF_SETUP2:   rdata_next = gword_reg[LCB_GW_SETUP2];
        `LCB_OFF_SETUP3:   rdata_next = gword_reg[LCB_GW_SETUP3];
        `LCB_OFF_UID_LO:   rdata_next = {16'h0, uid_lo_reg};
        `LCB_OFF_UID_MID:  rdata_next = {16'h0, uid_mid_reg};
        `LCB_OFF_FLOG:     rdata_next = gword_reg[LCB_GW_FLOG];
        `LCB_OFF_DIAG:     rdata_next = gword_reg[LCB_GW_DIAG];
        `LCB_OFF_HWINIT:   rdata_next = gword_reg[LCB_GW_HWINIT];
        `LCB_OFF_MAKER,
        `LCB_OFF_MIRROR:   rdata_next = MAKER_IDENT_VALUE;
        `LCB_OFF_PERF_COUNTER_COMMAND:   rdata_next = perf_counter_command_reg;
        `LCB_OFF_PERF_COUNTER_EXTENSION:   rdata_next = perf_counter_extension_reg;
        `LCB_OFF_PERF_COUNTER_SELECTOR:   rdata_next = perf_counter_selector_reg;
        `LCB_OFF_PERF_EVENT_TALLY:   rdata_next = perf_event_tally_reg;
        `LCB_OFF_SOFTWARE_MAILBOX_WORD:   rdata_next = gword_reg[LCB_GW_SOFTWARE_MAILBOX_WORD];
        `LCB_OFF_SW_CLR,
        `LCB_OFF_SW_SET:   rdata_next = sw_cond_reg;
        `LCB_OFF_LOCK:     rdata_next = gword_reg[LCB_GW_LOCK];
        default:           rdata_next = '0;
      endcase
    end
  end

  // acks and read data one cycle after the request is taken
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DWIN_ACK <= 1'b0;
      MWIN_ACK <= 1'b0;
      RDATA    <= `LCB_RESET_WORD;
    end else begin
      DWIN_ACK <= (src == LCB_SRC_DIRECT);
      MWIN_ACK <= (src == LCB_SRC_MAPPED);
      if (rd) RDATA <= rdata_next;
    end
  end

  assign CMD_RESET_PULSE = cmd_reset_reg;
  assign NODE_CONDITION  = node_cond_reg;
  assign NODE_ID         = node_id_reg;
  assign SYNC_SPACING    = sync_spacing_reg;
  assign ROUTE_CTRL      = rt_ctrl_reg;
  assign ROUTE_MASK      = rt_mask_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_reset_write;
    wr && acc_addr == `LCB_OFF_CMD_RST;
  endsequence
  sequence s_single_pulse;
    CMD_RESET_PULSE ##1 !CMD_RESET_PULSE;
  endsequence

  a_cmd_reset_pulse: assert property (s_reset_write |=> s_single_pulse)
    else $error("command reset pulse not one cycle after write");
  // properties spell the write decode out: a function body would see post-edge values
  a_cond_clear_bits: assert property (wr && acc_addr == `LCB_OFF_COND_CLR && NODE_COND_EVENTS == '0
    |=> (NODE_CONDITION & $past(acc_wdata)) == '0)
    else $error("node condition bits not cleared");
  a_cond_set_bits: assert property (wr && acc_addr == `LCB_OFF_COND_SET
    |=> (NODE_CONDITION & $past(acc_wdata)) == $past(acc_wdata))
    else $error("node condition bits not set");
  a_fault_count_up: assert property (FAULT_EVENT && !(wr && acc_addr == `LCB_OFF_FAULTS)
    |=> fault_tally_reg == $past(fault_tally_reg) + 32'h1)
    else $error("fault tally did not advance");
  a_perf_clear_only: assert property (wr && acc_addr == `LCB_OFF_PERF_EVENT_TALLY && !perf_tick
    |=> perf_event_tally_reg == '0)
    else $error("perf counter not cleared by write");
  a_sw_cond_set: assert property (wr && acc_addr == `LCB_OFF_SW_SET
    |=> (sw_cond_reg & $past(acc_wdata)) == $past(acc_wdata))
    else $error("software condition bits not set");
  a_sw_cond_clear: assert property (wr && acc_addr == `LCB_OFF_SW_CLR
    |=> (sw_cond_reg & $past(acc_wdata)) == '0)
    else $error("software condition bits not cleared");
  a_mirror_ident: assert property (rd && acc_addr == `LCB_OFF_MIRROR
    |=> RDATA == MAKER_IDENT_VALUE)
    else $error("mirror did not return maker ident");
  a_route_mask_out: assert property (wr && acc_addr == `LCB_OFF_RT_MASK
    |=> ROUTE_MASK == $past(acc_wdata))
    else $error("routing mask not taken");
  a_window_ack_order: assert property (DWIN_REQ && MWIN_REQ && !DWIN_ACK && !MWIN_ACK
    |=> DWIN_ACK && !MWIN_ACK ##1 !DWIN_ACK)
    else $error("direct window did not win the tie");
  a_unmapped_zero: assert property (rd && acc_addr == 20'h00100
    |=> RDATA == '0)
    else $error("unlisted offset read non-zero");

endmodule : lcb_csr_bank

// ### shared/lcb_csr_map.svh
// register offsets, field positions and reset values of the link controller csr bank
`ifndef LCB_CSR_MAP_SVH
`define LCB_CSR_MAP_SVH
`define LCB_ADDR_W        20
`define LCB_OFF_COND_CLR  20'h00000
`define LCB_OFF_COND_SET  20'h00004
`define LCB_OFF_NODE_IDENTIFIERS  20'h00008
`define LCB_OFF_CMD_RST   20'h0000C
`define LCB_OFF_FAULTS    20'h00180
`define LCB_OFF_SYNC      20'h00200
`define LCB_OFF_UID_UP    20'h00208
`define LCB_OFF_LINE_TBL  20'h00280
`define LCB_OFF_LINE_END  20'h002BC
`define LCB_OFF_BACK_TBL  20'h00300
`define LCB_OFF_BACK_END  20'h0033C
`define LCB_OFF_RT_CTRL   20'h00380
`define LCB_OFF_RT_MASK   20'h00384
`define LCB_OFF_SETUP1    20'h00388
`define LCB_OFF_SETUP2    20'h0038C
`define LCB_OFF_SETUP3    20'h00390
`define LCB_OFF_UID_LO    20'h00394
`define LCB_OFF_UID_MID   20'h00398
`define LCB_OFF_FLOG      20'h003A0
`define LCB_OFF_DIAG      20'h003A4
`define LCB_OFF_HWINIT    20'h003A8
`define LCB_OFF_MAKER     20'h003B0
`define LCB_OFF_PERF_COUNTER_COMMAND    20'h003B4
`define LCB_OFF_PERF_COUNTER_EXTENSION    20'h003B8
`define LCB_OFF_PERF_COUNTER_SELECTOR    20'h003BC
`define LCB_OFF_PERF_EVENT_TALLY    20'h003C0
`define LCB_OFF_SOFTWARE_MAILBOX_WORD    20'h003C4
`define LCB_OFF_SW_CLR    20'h003C8
`define LCB_OFF_SW_SET    20'h003CC
`define LCB_OFF_LOCK      20'hC03D0
`define LCB_OFF_MIRROR    20'h00400
`define LCB_PC_ENABLE_BIT 0
`define LCB_PERF_COUNTER_SELECTOR_W      5
`define LCB_RESET_WORD    32'h0000_0000
`define LCB_RESET_HALF    16'h0000
`endif

// ### shared/lcb_pkg.sv
// types shared by the link controller csr bank
package lcb_pkg;
  typedef logic [15:0] lcb_half_type;
  typedef lcb_half_type lcb_table_type [16];
  // which access window supplied the request in service
  typedef enum logic [1:0] {LCB_SRC_NONE, LCB_SRC_DIRECT, LCB_SRC_MAPPED} lcb_src_type;
  // general words with no side effects, kept in one array
  typedef enum logic [2:0] {
    LCB_GW_SETUP1, LCB_GW_SETUP2, LCB_GW_SETUP3, LCB_GW_FLOG,
    LCB_GW_DIAG, LCB_GW_HWINIT, LCB_GW_SOFTWARE_MAILBOX_WORD, LCB_GW_LOCK
  } lcb_gword_type;
endpackage : lcb_pkg

// ### tb/lcb_host_model.sv
// host bridge model: drives one csr access window of the bank
`timescale 1ns/1ps
`include "lcb_csr_map.svh"
module lcb_host_model (
  input  wire logic                    SYS_CLK,
  input  wire logic                    ACK,
  input  wire logic [31:0]             RDATA,
  output logic                         REQ,
  output logic                         WE,
  output logic [`LCB_ADDR_W-1:0]       ADDR,
  output logic [31:0]                  WDATA
);
  int waits;  // cycles from request to ack of the last access
  // ----
  // idle lines
  // ----
  initial begin
    REQ = 1'b0;
    WE = 1'b0;
    ADDR = 20'hFFFFF;
    WDATA = 32'hFFFF_FFFF;
    waits = 0;
  end
  // one word; held until ack or for at most 8 cycles, then released to inverted junk so stale
  // values are never mistaken for a live request
  task automatic access(input logic we, input logic [`LCB_ADDR_W-1:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
    @(negedge SYS_CLK);
    REQ = 1'b1;
    WE = we;
    ADDR = a;
    WDATA = wd;
    waits = 0;
    do begin
      @(negedge SYS_CLK);
      waits++;
    end while (ACK !== 1'b1 && waits < 8);
    rd = RDATA;
    REQ = 1'b0;
    WE = ~we;
    ADDR = ~a;
    WDATA = ~wd;
  endtask : access
endmodule : lcb_host_model

// ### tb/lcb_csr_bank_test.sv
// self-checking testbench of the link controller csr bank
`timescale 1ns/1ps
`include "lcb_csr_map.svh"
module lcb_csr_bank_test;
  import lcb_pkg::*;
  localparam logic [31:0] MAKER_V = 32'h0000_3C96;  // arbitrary value
  logic SYS_CLK, RESET_N, DWIN_REQ, DWIN_WE, DWIN_ACK, MWIN_REQ, MWIN_WE, MWIN_ACK;
  logic [`LCB_ADDR_W-1:0] DWIN_ADDR, MWIN_ADDR;
  logic [31:0] DWIN_WDATA, MWIN_WDATA, RDATA, NODE_COND_EVENTS, PERF_EVENTS;
  logic [31:0] NODE_CONDITION, SYNC_SPACING, ROUTE_CTRL, ROUTE_MASK;
  logic [15:0] STRAP_NODE_ID, NODE_ID;
  logic FAULT_EVENT, CMD_RESET_PULSE;
  int n_fail, checks_done;
  logic [`LCB_ADDR_W-1:0] rw_a [15] = '{`LCB_OFF_SYNC, `LCB_OFF_UID_UP, `LCB_OFF_RT_CTRL,
    `LCB_OFF_RT_MASK, `LCB_OFF_SETUP1, `LCB_OFF_SETUP2, `LCB_OFF_SETUP3, `LCB_OFF_UID_LO,
    `LCB_OFF_UID_MID, `LCB_OFF_FLOG, `LCB_OFF_DIAG, `LCB_OFF_HWINIT, `LCB_OFF_PERF_COUNTER_EXTENSION,
    `LCB_OFF_SOFTWARE_MAILBOX_WORD, `LCB_OFF_LOCK};
  // ----
  // design and the two host windows
  // ----
  lcb_csr_bank #(.MAKER_IDENT_VALUE(MAKER_V)) dut (.SYS_CLK, .RESET_N, .DWIN_REQ, .DWIN_WE,
    .DWIN_ADDR, .DWIN_WDATA, .DWIN_ACK, .MWIN_REQ, .MWIN_WE, .MWIN_ADDR, .MWIN_WDATA,
    .MWIN_ACK, .RDATA, .STRAP_NODE_ID, .NODE_COND_EVENTS, .FAULT_EVENT, .PERF_EVENTS,
    .CMD_RESET_PULSE, .NODE_CONDITION, .NODE_ID, .SYNC_SPACING, .ROUTE_CTRL, .ROUTE_MASK);
  lcb_host_model u_dir (.SYS_CLK, .ACK(DWIN_ACK), .RDATA, .REQ(DWIN_REQ), .WE(DWIN_WE),
    .ADDR(DWIN_ADDR), .WDATA(DWIN_WDATA));
  lcb_host_model u_map (.SYS_CLK, .ACK(MWIN_ACK), .RDATA, .REQ(MWIN_REQ), .WE(MWIN_WE),
    .ADDR(MWIN_ADDR), .WDATA(MWIN_WDATA));
  // 50 MHz clock
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  // ----
  // access and compare helpers
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // m selects the mapped window; the direct one must answer after one cycle
  task automatic acc(input bit m, input logic we, input logic [`LCB_ADDR_W-1:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    if (m) u_map.access(we, a, wd, rd);
    else begin
      u_dir.access(we, a, wd, rd);
      chk("direct ack delay", 32'd1, u_dir.waits);
    end
  endtask : acc
  task automatic wr(input bit m, input logic [`LCB_ADDR_W-1:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    acc(m, 1'b1, a, wd, rd);
  endtask : wr
  task automatic rdc(input bit m, input logic [`LCB_ADDR_W-1:0] a, input logic [31:0] e,
                     input string nm);
    logic [31:0] rd;
    acc(m, 1'b0, a, 32'h0000_0000, rd);
    chk(nm, e, rd);
  endtask : rdc
  // id words keep only the low half
  function automatic logic [31:0] keep(input logic [`LCB_ADDR_W-1:0] a, input logic [31:0] d);
    if (a == `LCB_OFF_UID_UP || a == `LCB_OFF_UID_LO || a == `LCB_OFF_UID_MID) begin
      return d & 32'h0000_FFFF;
    end
    return d;
  endfunction : keep
  function automatic logic [31:0] pat(input int i);
    return 32'h9E37_79B9 ^ (i << 8);
  endfunction : pat
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // ----
  // tests
  // ----
  // watchdog: whole run needs well under 3000 cycles
  initial begin
    #(20 * 20000);
    $display("watchdog expired");
    n_fail++;
    stop_test();
  end
  initial begin
    logic [`LCB_ADDR_W-1:0] sa, ca;
    RESET_N = 1'b0;
    STRAP_NODE_ID = 16'h0A51;
    NODE_COND_EVENTS = 32'h0000_0000;
    FAULT_EVENT = 1'b0;
    PERF_EVENTS = 32'h0000_0000;
    n_fail = 0;
    checks_done = 0;
    repeat (6) @(negedge SYS_CLK);
    RESET_N = 1'b1;
    @(negedge SYS_CLK);
    chk("node id out", 32'h0000_0A51, {16'h0000, NODE_ID});
    chk("condition out", 32'h0000_0000, NODE_CONDITION);
    rdc(0, `LCB_OFF_NODE_IDENTIFIERS, 32'h0A51_0A51, "node_identifiers");
    wr(1, `LCB_OFF_NODE_IDENTIFIERS, 32'hFFFF_1234);
    rdc(0, `LCB_OFF_NODE_IDENTIFIERS, 32'h0A51_1234, "node_identifiers");
    chk("node id out", 32'h0000_1234, {16'h0000, NODE_ID});
    $display("test node_identifiers done");
    // plain words: reset value, then write one window, read the other
    foreach (rw_a[i]) rdc(i % 2, rw_a[i], 32'h0000_0000, "word reset");
    foreach (rw_a[i]) wr(i % 2, rw_a[i], pat(i));
    foreach (rw_a[i]) rdc(~i[0], rw_a[i], keep(rw_a[i], pat(i)), "word");
    chk("sync spacing", pat(0), SYNC_SPACING);
    chk("route ctrl", pat(2), ROUTE_CTRL);
    chk("route mask", pat(3), ROUTE_MASK);
    $display("test plain words done");
    // all entries written before any read, so aliasing shows up
    for (int i = 0; i < 16; i++) begin
      wr(0, 20'(`LCB_OFF_LINE_TBL + 4 * i), 32'hFFFF_1100 + i);
      wr(1, 20'(`LCB_OFF_BACK_TBL + 4 * i), 32'hFFFF_2200 + i);
    end
    for (int i = 0; i < 16; i++) begin
      rdc(1, 20'(`LCB_OFF_LINE_TBL + 4 * i), 32'h0000_1100 + i, "line table");
      rdc(0, 20'(`LCB_OFF_BACK_TBL + 4 * i), 32'h0000_2200 + i, "back table");
    end
    $display("test route tables done");
    // set and clear ports of both condition words
    for (int k = 0; k < 2; k++) begin
      sa = k ? `LCB_OFF_SW_SET : `LCB_OFF_COND_SET;
      ca = k ? `LCB_OFF_SW_CLR : `LCB_OFF_COND_CLR;
      wr(k[0], sa, 32'hF0F0_00FF);
      wr(k[0], ca, 32'h0000_000F);
      rdc(~k[0], sa, 32'hF0F0_00F0, "cond via set port");
      rdc(k[0], ca, 32'hF0F0_00F0, "cond via clear port");
    end
    chk("condition out", 32'hF0F0_00F0, NODE_CONDITION);
    NODE_COND_EVENTS = 32'h0000_0100;
    wr(0, `LCB_OFF_COND_CLR, 32'h0000_0110);
    NODE_COND_EVENTS = 32'h0000_0000;
    rdc(0, `LCB_OFF_COND_CLR, 32'hF0F0_01E0, "cond event over clear");
    $display("test condition ports done");
    // fault tally counts one per high cycle
    wr(0, `LCB_OFF_FAULTS, 32'h0000_0000);
    FAULT_EVENT = 1'b1;
    repeat (5) @(negedge SYS_CLK);
    FAULT_EVENT = 1'b0;
    rdc(1, `LCB_OFF_FAULTS, 32'h0000_0005, "fault tally");
    // perf counter: only the selected line counts, writes only clear
    wr(0, `LCB_OFF_PERF_COUNTER_SELECTOR, 32'h0000_0003);
    wr(1, `LCB_OFF_PERF_COUNTER_COMMAND, 32'h0000_0001);
    wr(0, `LCB_OFF_PERF_EVENT_TALLY, 32'h0000_0055);
    PERF_EVENTS = 32'h0000_0008;
    repeat (4) @(negedge SYS_CLK);
    PERF_EVENTS = 32'hFFFF_FFF7;
    repeat (3) @(negedge SYS_CLK);
    PERF_EVENTS = 32'h0000_0000;
    rdc(1, `LCB_OFF_PERF_EVENT_TALLY, 32'h0000_0004, "perf tally");
    rdc(0, `LCB_OFF_PERF_COUNTER_SELECTOR, 32'h0000_0003, "perf selector");
    wr(0, `LCB_OFF_PERF_EVENT_TALLY, 32'hFFFF_0000);
    rdc(0, `LCB_OFF_PERF_EVENT_TALLY, 32'h0000_0000, "perf cleared");
    wr(1, `LCB_OFF_PERF_COUNTER_COMMAND, 32'h0000_0000);
    PERF_EVENTS = 32'h0000_0008;
    repeat (3) @(negedge SYS_CLK);
    PERF_EVENTS = 32'h0000_0000;
    rdc(1, `LCB_OFF_PERF_EVENT_TALLY, 32'h0000_0000, "perf disabled");
    $display("test counters done");
    // maker ident, its mirror and unlisted offsets
    wr(1, `LCB_OFF_MAKER, ~MAKER_V);
    rdc(0, `LCB_OFF_MAKER, MAKER_V, "maker ident");
    rdc(1, `LCB_OFF_MIRROR, MAKER_V, "maker mirror");
    wr(0, 20'h00100, 32'hFFFF_FFFF);
    rdc(1, 20'h00100, 32'h0000_0000, "unlisted");
    rdc(0, 20'h003AC, 32'h0000_0000, "unlisted");
    rdc(1, 20'h00404, 32'h0000_0000, "unlisted");
    // both windows at once: direct served first, mapped one cycle later
    fork
      wr(0, `LCB_OFF_SOFTWARE_MAILBOX_WORD, 32'h1111_2222);
      wr(1, `LCB_OFF_SETUP1, 32'h3333_4444);
    join
    chk("mapped ack delay", 32'd2, u_map.waits);
    rdc(1, `LCB_OFF_SOFTWARE_MAILBOX_WORD, 32'h1111_2222, "contended direct");
    rdc(0, `LCB_OFF_SETUP1, 32'h3333_4444, "contended mapped");
    $display("test ident and windows done");
    // command reset reloads ids from strap and condition from events
    STRAP_NODE_ID = 16'h0C3E;
    NODE_COND_EVENTS = 32'h0000_0002;
    wr(0, `LCB_OFF_CMD_RST, 32'h0000_0000);
    chk("reset pulse", 32'd1, {31'd0, CMD_RESET_PULSE});
    @(negedge SYS_CLK);
    chk("reset pulse end", 32'd0, {31'd0, CMD_RESET_PULSE});
    NODE_COND_EVENTS = 32'h0000_0000;
    @(negedge SYS_CLK);
    chk("condition reload", 32'h0000_0002, NODE_CONDITION);
    rdc(1, `LCB_OFF_NODE_IDENTIFIERS, 32'h0C3E_0C3E, "ids after cmd reset");
    rdc(0, `LCB_OFF_CMD_RST, 32'h0000_0000, "trigger reads");
    $display("test command reset done");
    // second chip reset in mid-run
    RESET_N = 1'b0;
    repeat (2) @(negedge SYS_CLK);
    chk("sync in reset", 32'h0000_0000, SYNC_SPACING);
    RESET_N = 1'b1;
    @(negedge SYS_CLK);
    rdc(1, `LCB_OFF_SYNC, 32'h0000_0000, "sync after reset");
    $display("test second reset done");
    stop_test();
  end
endmodule : lcb_csr_bank_test
